// File: bio_seq_defines.svh
`ifndef BIO_SEQ_DEFINES_SVH
`define BIO_SEQ_DEFINES_SVH

// ****************************************************************
// timing
// ****************************************************************
`define CLOCK_MHZ          200
`define TSTATE_NS          250
// cycles of the 200 MHz clock per processor T state, rounded down
`define TSTATE_CYCLES      ((`TSTATE_NS * `CLOCK_MHZ) / 1000)
`define FETCH_TSTATES      3'h4
`define DECODE_TSTATES     3'h5
`define MREAD_TSTATES      3'h3
`define IOWRITE_TSTATES    3'h4
`define REWIND_TSTATES     3'h5

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CTRL           32'h0000_0000
`define OFS_PORT           32'h0000_0004
`define OFS_COUNT          32'h0000_0008
`define OFS_POINTER        32'h0000_000c
`define OFS_PC             32'h0000_0010
`define OFS_FLAGS          32'h0000_0014
`define OFS_STATUS         32'h0000_0018
`define OFS_LATCH          32'h0000_001c

// ****************************************************************
// reset values
// ****************************************************************
`define RST_PORT           8'h00
`define RST_COUNT          8'h00
`define RST_POINTER        16'h0000
`define RST_PC             16'h0000
`define RST_FLAGS          8'h00

// ****************************************************************
// flag and status bit positions
// ****************************************************************
`define FLAG_C             0
`define FLAG_N             1
`define FLAG_PV            2
`define FLAG_H             4
`define FLAG_Z             6
`define FLAG_S             7
`define STAT_BUSY          0
`define STAT_DONE          1
`define STAT_ILLEGAL       2
`define STAT_INTERRUPTED   3

// ****************************************************************
// instruction encodings
// ****************************************************************
`define OPC_PREFIX         8'hed
`define OPC_INCR_ONCE      8'ha3
`define OPC_INCR_REPEAT    8'hb3
`define OPC_DECR_ONCE      8'hab
`define OPC_DECR_REPEAT    8'hbb

`endif

// File: bio_seq_pkg.sv
`default_nettype none
package bio_seq_pkg;

  // ****************************************************************
  // machine cycles
  // ****************************************************************
  typedef enum logic [5:0] {
    ST_IDLE    = 6'b000001,
    ST_FETCH   = 6'b000010,
    ST_DECODE  = 6'b000100,
    ST_MREAD   = 6'b001000,
    ST_IOWRITE = 6'b010000,
    ST_REWIND  = 6'b100000
  } mcycle_t;

  // ****************************************************************
  // state records
  // ****************************************************************
  typedef struct packed {
    mcycle_t     fsm;
    logic [15:0] divCnt;
    logic [2:0]  tState;
    logic [15:0] instr;
    logic        repeatMode;
    logic        decrMode;
    logic [7:0]  port;
    logic [7:0]  count;
    logic [15:0] pointer;
    logic [15:0] pc;
    logic [7:0]  flags;
    logic [7:0]  latch;
    logic [6:0]  refreshR;
    logic        done;
    logic        illegal;
    logic        interrupted;
    logic        intAccept;
    logic [7:0]  dataSync1;
    logic [7:0]  dataSync2;
    logic        intSync1;
    logic        intSync2;
    logic [15:0] address;
    logic [7:0]  dataOut;
    logic        dataOe;
    logic        memReadN;
    logic        ioWriteN;
    logic        refreshN;
  } seq_state_t;

  typedef struct packed {
    logic        wrPend;
    logic [31:0] wrAddr;
    logic [31:0] rdData;
  } slave_state_t;

endpackage : bio_seq_pkg
`default_nettype wire

// File: reg_link_if.sv
`default_nettype none
interface reg_link_if;
  logic        wrStrobe;
  logic [31:0] wrAddr;
  logic [31:0] wrData;
  logic [31:0] rdAddr;
  logic [31:0] rdData;

  modport bus  (output wrStrobe, output wrAddr, output wrData, output rdAddr, input rdData);
  modport regs (input wrStrobe, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : reg_link_if
`default_nettype wire

// File: ahb_reg_port.sv
`include "bio_seq_defines.svh"
`default_nettype none
module ahb_reg_port
  import bio_seq_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // register side
  reg_link_if.bus          link
);

  slave_state_t s;
  slave_state_t next_s;
  logic         accept;

  // never waits and never errors, so the bus sees OKAY with zero wait states
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = s.rdData;
  assign link.wrStrobe = s.wrPend;
  assign link.wrAddr   = s.wrAddr;
  assign link.wrData   = hwdata;
  assign link.rdAddr   = haddr;

  always_comb begin
    next_s = s;
    accept = hsel && htrans[1] && hready;
    // only whole-word writes land; narrower ones complete but change nothing
    next_s.wrPend = accept && hwrite && (hsize == 3'h2);
    if (accept) begin
      next_s.wrAddr = haddr;
    end
    if (accept && !hwrite) begin
      next_s.rdData = link.rdData;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : ahb_reg_port
`default_nettype wire

// File: block_io_output_sequencer.sv
// Summary of operation
// - put the pointer pair on the address bus and read that memory byte
// - hold the memory byte in a latch until the I/O write drives it
// - decrement the byte counter after the memory read, before the I/O write
// - drive the port register on A0..A7 during the I/O write
// - drive the decremented byte counter on A8..A15 during the I/O write
// - drive the latched byte on the data bus; the peripheral takes it
// - incrementing forms add one to the pointer pair last
// - decrementing forms subtract one from the pointer pair last
// - single forms take four machine cycles of 4, 5, 3 and 4 T states
// - single forms set zero flag when decremented counter is zero, else clear
// - sign, half-carry, parity undefined; subtract set; carry unchanged
// - repeating forms move the program counter back two while counter nonzero
// - repeating forms stop at counter zero with the zero flag set
// - repeating forms accept interrupts and run two refresh cycles per byte
// - a repeating start with counter zero wraps and outputs 256 bytes
// - repeating decrement form steps the pointer on the same edge as the repeat test
//
// Chosen here: the register addresses and register access over AHB-Lite.
`include "bio_seq_defines.svh"
`default_nettype none
module block_io_output_sequencer
  import bio_seq_pkg::*;
#(
  parameter int unsigned TSTATE_CYCLES = `TSTATE_CYCLES
)(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // processor bus
  output logic [15:0]      address,
  output logic [7:0]       dataOut,
  input  wire logic [7:0]  dataIn,
  output logic             dataOe,
  output logic             memReadN,
  output logic             ioWriteN,
  output logic             refreshN,
  // interrupt
  input  wire logic        intRequest,
  output logic             intAccept
);

  // ****************************************************************
  // state and register port
  // ****************************************************************
  seq_state_t s;
  seq_state_t next_s;
  logic       tick;
  logic       busy;

  reg_link_if link ();

  ahb_reg_port u_ahb_reg_port (
    .clock     (clock),
    .reset     (reset),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .link      (link.bus)
  );

  assign address  = s.address;
  assign dataOut  = s.dataOut;
  assign dataOe   = s.dataOe;
  assign memReadN = s.memReadN;
  assign ioWriteN = s.ioWriteN;
  assign refreshN = s.refreshN;
  assign intAccept = s.intAccept;
  assign busy     = (s.fsm != ST_IDLE);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [2:0] lastTState(input mcycle_t m);
    logic [2:0] len;
    len = 3'h1;
    unique case (m)
      ST_FETCH:   len = `FETCH_TSTATES;
      ST_DECODE:  len = `DECODE_TSTATES;
      ST_MREAD:   len = `MREAD_TSTATES;
      ST_IOWRITE: len = `IOWRITE_TSTATES;
      ST_REWIND:  len = `REWIND_TSTATES;
      ST_IDLE:    len = 3'h1;
    endcase
    return len - 3'h1;
  endfunction : lastTState

  function automatic logic validOpcode(input logic [15:0] ins);
    return (ins[15:8] == `OPC_PREFIX) &&
           ((ins[7:0] == `OPC_INCR_ONCE) || (ins[7:0] == `OPC_INCR_REPEAT) ||
            (ins[7:0] == `OPC_DECR_ONCE) || (ins[7:0] == `OPC_DECR_REPEAT));
  endfunction : validOpcode

  // ****************************************************************
  // register read mux
  // ****************************************************************
  always_comb begin
    link.rdData = '0;
    case (link.rdAddr)
      `OFS_CTRL:    link.rdData = {16'h0000, s.instr};
      `OFS_PORT:    link.rdData = {24'h000000, s.port};
      `OFS_COUNT:   link.rdData = {24'h000000, s.count};
      `OFS_POINTER: link.rdData = {16'h0000, s.pointer};
      `OFS_PC:      link.rdData = {16'h0000, s.pc};
      `OFS_FLAGS:   link.rdData = {24'h000000, s.flags};
      `OFS_STATUS:  link.rdData = {28'h0000000, s.interrupted, s.illegal, s.done, busy};
      `OFS_LATCH:   link.rdData = {24'h000000, s.latch};
      default:      link.rdData = '0;
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.intAccept = 1'b0;
    // pins from outside the clock domain: first stage feeds only the second
    next_s.dataSync1 = dataIn;
    next_s.dataSync2 = s.dataSync1;
    next_s.intSync1  = intRequest;
    next_s.intSync2  = s.intSync1;

    tick = (s.divCnt == 16'(TSTATE_CYCLES - 1));
    next_s.divCnt = tick ? 16'h0000 : s.divCnt + 16'h0001;

    // register writes from the bus are ignored while an instruction runs
    if (link.wrStrobe && !busy) begin
      case (link.wrAddr)
        `OFS_CTRL: begin
          next_s.instr = link.wrData[15:0];
          if (validOpcode(link.wrData[15:0])) begin
            next_s.repeatMode  = link.wrData[4];
            next_s.decrMode    = link.wrData[3];
            next_s.fsm         = ST_FETCH;
            next_s.tState      = 3'h0;
            next_s.divCnt      = 16'h0000;
            next_s.done        = 1'b0;
            next_s.illegal     = 1'b0;
            next_s.interrupted = 1'b0;
          end else begin
            next_s.illegal = 1'b1;
            next_s.done    = 1'b0;
          end
        end
        `OFS_PORT:    next_s.port    = link.wrData[7:0];
        `OFS_COUNT:   next_s.count   = link.wrData[7:0];
        `OFS_POINTER: next_s.pointer = link.wrData[15:0];
        `OFS_PC:      next_s.pc      = link.wrData[15:0];
        `OFS_FLAGS:   next_s.flags   = link.wrData[7:0];
        default:      next_s.instr   = s.instr;
      endcase
    end

    if (tick && busy) begin
      if (s.tState != lastTState(s.fsm)) begin
        next_s.tState = s.tState + 3'h1;
      end else begin
        next_s.tState = 3'h0;
        unique case (s.fsm)
          ST_FETCH: begin
            next_s.pc       = s.pc + 16'h0001;
            next_s.refreshR = s.refreshR + 7'h01;
            next_s.fsm      = ST_DECODE;
          end
          ST_DECODE: begin
            next_s.pc       = s.pc + 16'h0001;
            next_s.refreshR = s.refreshR + 7'h01;
            next_s.fsm      = ST_MREAD;
          end
          ST_MREAD: begin
            next_s.latch = s.dataSync2;
            // eight-bit wrap makes a zero count run 256 transfers in the repeating forms
            next_s.count = s.count - 8'h01;
            next_s.fsm   = ST_IOWRITE;
          end
          ST_IOWRITE: begin
            // pointer steps on the same edge as the repeat test below
            if (s.decrMode) begin
              next_s.pointer = s.pointer - 16'h0001;
            end else begin
              next_s.pointer = s.pointer + 16'h0001;
            end
            // undefined flags are simply left as they were
            next_s.flags[`FLAG_N] = 1'b1;
            next_s.flags[`FLAG_Z] = (s.count == 8'h00);
            if (s.repeatMode && (s.count != 8'h00)) begin
              next_s.fsm = ST_REWIND;
            end else begin
              next_s.fsm  = ST_IDLE;
              next_s.done = 1'b1;
            end
          end
          ST_REWIND: begin
            next_s.pc = s.pc - 16'h0002;
            if (s.intSync2) begin
              // leave with the program counter rewound so a return resumes the loop
              next_s.fsm         = ST_IDLE;
              next_s.interrupted = 1'b1;
              next_s.intAccept   = 1'b1;
            end else begin
              next_s.fsm = ST_FETCH;
            end
          end
          ST_IDLE: begin
            next_s.fsm = ST_IDLE;
          end
        endcase
      end
    end

    // ****************************************************************
    // bus pins for the coming T state
    // ****************************************************************
    next_s.address  = 16'h0000;
    next_s.dataOut  = next_s.latch;
    next_s.dataOe   = 1'b0;
    next_s.memReadN = 1'b1;
    next_s.ioWriteN = 1'b1;
    next_s.refreshN = 1'b1;
    unique case (next_s.fsm)
      ST_FETCH, ST_DECODE: begin
        if (next_s.tState < 3'h2) begin
          next_s.address = next_s.pc;
        end else begin
          next_s.address  = {9'h000, next_s.refreshR};
          next_s.refreshN = 1'b0;
        end
      end
      ST_MREAD: begin
        next_s.address  = next_s.pointer;
        next_s.memReadN = 1'b0;
      end
      ST_IOWRITE: begin
        next_s.address  = {next_s.count, next_s.port};
        next_s.dataOe   = 1'b1;
        next_s.ioWriteN = !((next_s.tState == 3'h1) || (next_s.tState == 3'h2));
      end
      ST_REWIND, ST_IDLE: begin
        next_s.address = 16'h0000;
      end
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      s          <= '0;
      s.fsm      <= ST_IDLE;
      s.port     <= `RST_PORT;
      s.count    <= `RST_COUNT;
      s.pointer  <= `RST_POINTER;
      s.pc       <= `RST_PC;
      s.flags    <= `RST_FLAGS;
      s.memReadN <= 1'b1;
      s.ioWriteN <= 1'b1;
      s.refreshN <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

endmodule : block_io_output_sequencer
`default_nettype wire

// File: bio_seq_monitor.sv
`default_nettype none
module bio_seq_monitor #(
  parameter int unsigned TSTATE_CYCLES = 50
)(
  // clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // processor bus
  input wire logic [15:0] address,
  input wire logic [7:0]  dataOut,
  input wire logic        dataOe,
  input wire logic        memReadN,
  input wire logic        ioWriteN,
  input wire logic        refreshN,
  input wire logic        intAccept
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // strobe widths
  // ****
  logic [15:0] rdRun;
  logic [15:0] wrRun;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // counters rather than repetition, the strobe width scales with the parameter
  always_ff @(posedge clock) begin
    rdRun <= (reset || memReadN) ? 16'h0 : rdRun + 16'h1;
    wrRun <= (reset || ioWriteN) ? 16'h0 : wrRun + 16'h1;
  end
  property p_read_addr; !memReadN && $past(!memReadN) |-> $stable(address); endproperty
  a_read_addr: assert property (p_read_addr) else $error("read address moved");
  property p_read_len; $rose(memReadN) |-> rdRun == 16'(3 * TSTATE_CYCLES); endproperty
  a_read_len: assert property (p_read_len) else $error("memory read width");
  property p_write_len; $rose(ioWriteN) |-> wrRun == 16'(2 * TSTATE_CYCLES); endproperty
  a_write_len: assert property (p_write_len) else $error("io write width");
  property p_hold_byte; dataOe && $past(dataOe) |-> $stable(dataOut); endproperty
  a_hold_byte: assert property (p_hold_byte) else $error("data moved");
  property p_write_drive; !ioWriteN |-> dataOe && $past(dataOe); endproperty
  a_write_drive: assert property (p_write_drive) else $error("write undriven");
  property p_port_addr; dataOe && $past(dataOe) |-> $stable(address); endproperty
  a_port_addr: assert property (p_port_addr) else $error("port address moved");
  property p_no_overlap; !memReadN |-> ioWriteN && !dataOe && refreshN; endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("strobes overlap");
  property p_refresh; !refreshN |-> address[15:7] == 9'h0; endproperty
  a_refresh: assert property (p_refresh) else $error("refresh address");
  property p_int_pulse; intAccept |=> !intAccept; endproperty
  a_int_pulse: assert property (p_int_pulse) else $error("accept too long");
  c_int: cover property (intAccept);
  c_write: cover property ($fell(ioWriteN));
  c_refresh: cover property ($fell(refreshN));
endmodule : bio_seq_monitor

bind block_io_output_sequencer bio_seq_monitor #(.TSTATE_CYCLES(TSTATE_CYCLES)) mon (
  .clock(clock), .reset(reset), .address(address), .dataOut(dataOut), .dataOe(dataOe),
  .memReadN(memReadN), .ioWriteN(ioWriteN), .refreshN(refreshN), .intAccept(intAccept));
`default_nettype wire

// File: bio_bus_model.sv
`default_nettype none
module bio_bus_model (
  // clock
  input wire logic        clock,
  // processor bus
  input wire logic [15:0] address,
  input wire logic [7:0]  dataOut,
  input wire logic        dataOe,
  input wire logic        memReadN,
  input wire logic        ioWriteN,
  output logic [7:0]      dataIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [0:65535];
  logic [23:0] outLog [$];
  logic        wasLow;
  initial begin
    dataIn = 8'h00;
    wasLow = 1'b0;
  end
  always @(posedge clock) begin
    // released bus toggles so a stale byte cannot pass as a read
    dataIn <= memReadN ? ~dataIn : mem[address];
    if (!ioWriteN && !wasLow && dataOe) outLog.push_back({address, dataOut});
    wasLow <= !ioWriteN;
  end
endmodule : bio_bus_model
`default_nettype wire

// File: tb_block_io_output_sequencer.sv
`include "bio_seq_defines.svh"
`default_nettype none
`define CHECK(g, e) begin nChecks++; if ((g) !== (e)) begin failCount++; \
  $display("BAD %0t got %h want %h", $time, g, e); end end
module tb_block_io_output_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, reset, hsel, hwrite, hready, hresp, dataOe, memReadN, ioWriteN;
  logic refreshN, intRequest, intAccept;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] address;
  logic [7:0]  dataOut, dataIn;
  int          failCount = 0;
  int          nChecks = 0;
  int          nAccept = 0;
  int          nRefresh = 0;
  logic        refreshWas = 1'b1;
  block_io_output_sequencer #(.TSTATE_CYCLES(2)) dut (.clock(clock), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .address(address), .dataOut(dataOut), .dataIn(dataIn), .dataOe(dataOe),
    .memReadN(memReadN), .ioWriteN(ioWriteN), .refreshN(refreshN),
    .intRequest(intRequest), .intAccept(intAccept));
  bio_bus_model periph (.clock(clock), .address(address), .dataOut(dataOut), .dataOe(dataOe),
    .memReadN(memReadN), .ioWriteN(ioWriteN), .dataIn(dataIn));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // pulse counters for outputs that no register shows
  always @(posedge clock) begin
    if (intAccept === 1'b1) nAccept <= nAccept + 1;
    if (refreshN === 1'b0 && refreshWas) nRefresh <= nRefresh + 1;
    refreshWas <= (refreshN !== 1'b0);
  end
  // ****
  // bus tasks
  // ****
  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : reportAndStop
  task automatic waitReady;
    for (int i = 0; i < 50; i++) begin
      @(posedge clock);
      if (hready === 1'b1) return;
    end
    failCount++;
    reportAndStop;
  endtask : waitReady
  task automatic busCycle(input logic [31:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    waitReady;
    htrans <= 2'h0;
    hwdata <= d;
    waitReady;
    rd = hrdata;
  endtask : busCycle
  task automatic waitIdle;
    for (int i = 0; i < 20000; i++) begin
      busCycle(`OFS_STATUS, 1'b0, 32'h0);
      if (rd[0] === 1'b0) return;
    end
    failCount++;
    reportAndStop;
  endtask : waitIdle
  task automatic runCase(input logic [7:0] op, input logic [7:0] cnt, input logic [15:0] ptr,
                         input logic [7:0] port);
    int n;
    int r0;
    logic [15:0] p;
    n = !op[4] ? 1 : (cnt == 8'h00 ? 256 : int'(cnt));
    r0 = nRefresh;
    for (int i = 0; i < n; i++) periph.mem[16'(op[3] ? ptr - i : ptr + i)] = 8'(i * 7) ^ 8'h5a;
    periph.outLog.delete();
    busCycle(`OFS_PORT, 1'b1, {24'h0, port});
    busCycle(`OFS_COUNT, 1'b1, {24'h0, cnt});
    busCycle(`OFS_POINTER, 1'b1, {16'h0, ptr});
    busCycle(`OFS_PC, 1'b1, 32'h0000_0100);
    busCycle(`OFS_FLAGS, 1'b1, {31'h0, cnt[0]});
    busCycle(`OFS_CTRL, 1'b1, {16'h0, `OPC_PREFIX, op});
    // ignored while busy, so the port seen on the bus must not change
    busCycle(`OFS_PORT, 1'b1, 32'h0000_00ff);
    waitIdle;
    `CHECK(periph.outLog.size(), n)
    `CHECK(nRefresh - r0, 2 * n)
    for (int i = 0; i < n; i++) begin
      p = 16'(op[3] ? ptr - i : ptr + i);
      `CHECK(periph.outLog[i], {8'(cnt - 1 - i), port, periph.mem[p]})
    end
    busCycle(`OFS_COUNT, 1'b0, 32'h0);
    `CHECK(rd, {24'h0, 8'(cnt - n)})
    busCycle(`OFS_POINTER, 1'b0, 32'h0);
    `CHECK(rd[15:0], 16'(op[3] ? ptr - n : ptr + n))
    busCycle(`OFS_FLAGS, 1'b0, 32'h0);
    `CHECK({rd[6], rd[1], rd[0]}, {8'(cnt - n) == 8'h00, 1'b1, cnt[0]})
    busCycle(`OFS_PC, 1'b0, 32'h0);
    `CHECK(rd, 32'h0000_0102)
    busCycle(`OFS_STATUS, 1'b0, 32'h0);
    `CHECK(rd[3:0], 4'h2)
  endtask : runCase
  // ****
  // sequence
  // ****
  initial begin
    reset = 1'b1;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    intRequest = 1'b0;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    runCase(`OPC_INCR_ONCE, 8'h10, 16'h1000, 8'h07);
    runCase(`OPC_DECR_ONCE, 8'h01, 16'h1000, 8'h07);
    runCase(`OPC_INCR_REPEAT, 8'h03, 16'h1000, 8'h07);
    runCase(`OPC_DECR_REPEAT, 8'h03, 16'h1000, 8'h07);
    runCase(`OPC_INCR_REPEAT, 8'h00, 16'hff80, 8'h3c);
    runCase(`OPC_DECR_REPEAT, 8'h02, 16'h0000, 8'hc3);
    intRequest <= 1'b1;
    busCycle(`OFS_COUNT, 1'b1, 32'h0000_0005);
    busCycle(`OFS_POINTER, 1'b1, 32'h0000_1000);
    busCycle(`OFS_PC, 1'b1, 32'h0000_0100);
    busCycle(`OFS_CTRL, 1'b1, {16'h0, `OPC_PREFIX, `OPC_INCR_REPEAT});
    waitIdle;
    intRequest <= 1'b0;
    `CHECK({rd[3], rd[0]}, 2'b10)
    `CHECK(nAccept, 1)
    busCycle(`OFS_COUNT, 1'b0, 32'h0);
    `CHECK(rd, 32'h0000_0004)
    busCycle(`OFS_PC, 1'b0, 32'h0);
    `CHECK(rd, 32'h0000_0100)
    busCycle(`OFS_CTRL, 1'b1, {16'h0, `OPC_PREFIX, 8'ha2});
    busCycle(`OFS_STATUS, 1'b0, 32'h0);
    `CHECK({rd[2], rd[0]}, 2'b10)
    busCycle(32'h0000_0040, 1'b0, 32'h0);
    `CHECK(rd, 32'h0)
    reportAndStop;
  end
endmodule : tb_block_io_output_sequencer
`default_nettype wire
